// *** pulse_out_pkg.sv ***
// Purpose: constants and types for the binary / relay output function block
// Assumes: pclk at 100 MHz, a millisecond tick derived inside the block
// Notes:   register map is reached over APB, one aligned 32-bit word per register
// Function
// - two base outputs plus three optional relay outputs, each with its own function
// - off function keeps the contact open whatever happens
// - device-alive function holds the contact closed while running
// - limit function closes contact for the pulse length on each group signal; the code drops signals that come during a pulse or its 50 ms low time
// - energy function tracks consumed or supplied energy of selected quantity
// - one pulse each time accumulated energy grows by the increment
// - pulse high time 50 ms to 500 ms in 50 ms steps
// - low time between pulses follows measured power
// - at least 50 ms low after every energy pulse
// - pulse rate bounded by pulse time plus minimum low time
// - rotation function closes for clockwise, opens for anticlockwise
package pulse_out_pkg;

	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S;
	localparam int unsigned STEP_MS       = 50;
	localparam int unsigned MIN_LOW_MS    = 50;
	localparam int unsigned MAX_STEPS     = 10;
	localparam int unsigned NUM_BASE      = 2;
	localparam int unsigned NUM_RELAY     = 3;
	localparam int unsigned NUM_OUT       = NUM_BASE + NUM_RELAY;
	localparam int unsigned ENERGY_W      = 32;
	localparam int unsigned CNT_W         = 10;

	// register byte offsets
	localparam logic [11:0] OFS_CFG_BASE  = 12'h000;
	localparam logic [11:0] OFS_INC_BASE  = 12'h020;
	localparam logic [11:0] OFS_STATUS    = 12'h040;
	localparam logic [11:0] OFS_CTRL      = 12'h044;

	// config word field positions
	localparam int unsigned FUNC_LSB      = 0;
	localparam int unsigned STEPS_LSB     = 3;
	localparam int unsigned DIR_BIT       = 7;
	localparam int unsigned SRC_LSB       = 8;
	localparam int unsigned GRP_LSB       = 10;
	localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
	localparam logic [31:0] INC_RESET     = 32'h0000_0001;

	typedef enum logic [2:0]
	{
		FN_OFF    = 3'h0,
		FN_ALIVE  = 3'h1,
		FN_LIMIT  = 3'h2,
		FN_ENERGY = 3'h3,
		FN_ROTATE = 3'h4
	} func_t;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW  = 3'b100
	} pulse_st_t;

	typedef struct packed
	{
		logic [2:0] group;      // limit group index
		logic [1:0] source;     // measured quantity / point selector
		logic       supply;     // 1 = supplied energy, 0 = consumed
		logic [3:0] steps;      // pulse length in 50 ms steps
		func_t      func;
	} out_cfg_t;

	// stored width of one config word; upper write data bits are dropped
	localparam int unsigned CFG_W         = $bits(out_cfg_t);

	// energy sample handed to every output each millisecond
	typedef struct packed
	{
		logic [15:0] consumed;
		logic [15:0] supplied;
	} energy_t;

endpackage

// *** pulse_timer.sv ***
`timescale 1ns/1ns
// Purpose: one output channel: energy accumulator and pulse shaper
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   high and low intervals are counted in ticks
module pulse_timer
(
	input  wire logic                                      pclk,
	input  wire logic                                      presetn,
	input  wire logic                                      tick,
	input  wire pulse_out_pkg::out_cfg_t                   cfg,
	input  wire logic [pulse_out_pkg::ENERGY_W-1:0]        increment,
	input  wire logic [15:0]                               energy_in,
	input  wire logic                                      trigger,
	output logic                                           busy,
	output logic                                           pulse
);

	logic [pulse_out_pkg::ENERGY_W-1:0] acc_q;
	logic [pulse_out_pkg::CNT_W-1:0]    cnt_q;
	logic [pulse_out_pkg::CNT_W-1:0]    high_ms;
	logic [pulse_out_pkg::CNT_W-1:0]    low_ms;
	logic                               due;
	logic                               start;
	logic                               energy_mode;
	pulse_out_pkg::pulse_st_t           st_q;

	////////////////////////////////////////////////////////////////////////////

	// steps outside 1..10 are clamped so the high time never leaves its range
	always_comb
	begin
		high_ms = pulse_out_pkg::CNT_W'(pulse_out_pkg::STEP_MS);
		if (cfg.steps >= 4'(pulse_out_pkg::MAX_STEPS))
			high_ms = pulse_out_pkg::CNT_W'(pulse_out_pkg::STEP_MS * pulse_out_pkg::MAX_STEPS);
		else if (cfg.steps != 4'h0)
			high_ms = pulse_out_pkg::CNT_W'(pulse_out_pkg::STEP_MS * cfg.steps);
	end

	assign low_ms      = pulse_out_pkg::CNT_W'(pulse_out_pkg::MIN_LOW_MS);
	assign energy_mode = (cfg.func == pulse_out_pkg::FN_ENERGY);
	assign due         = energy_mode ? (acc_q >= increment && increment != '0) : trigger;
	// a due pulse follows the minimum low time at once, so the period is pulse plus low
	assign start       = due && (st_q == pulse_out_pkg::ST_IDLE
		|| (st_q == pulse_out_pkg::ST_LOW && cnt_q == '0));

	// accumulation never pauses; only one increment is taken per pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_q <= '0;
		else if (!energy_mode)
			acc_q <= '0;
		else if (tick)
		begin
			if (start)
				acc_q <= acc_q - increment + pulse_out_pkg::ENERGY_W'(energy_in);
			else
				acc_q <= acc_q + pulse_out_pkg::ENERGY_W'(energy_in);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q  <= pulse_out_pkg::ST_IDLE;
			cnt_q <= '0;
		end
		else if (tick)
		begin
			case (st_q)
				pulse_out_pkg::ST_IDLE:
					if (start)
					begin
						st_q  <= pulse_out_pkg::ST_HIGH;
						cnt_q <= high_ms - 1'b1;
					end
				pulse_out_pkg::ST_HIGH:
					if (cnt_q == '0)
					begin
						st_q  <= pulse_out_pkg::ST_LOW;
						cnt_q <= low_ms - 1'b1;
					end
					else
						cnt_q <= cnt_q - 1'b1;
				pulse_out_pkg::ST_LOW:
					// rate bound: no new pulse until high plus minimum low has passed
					if (start)
					begin
						st_q  <= pulse_out_pkg::ST_HIGH;
						cnt_q <= high_ms - 1'b1;
					end
					else if (cnt_q == '0)
						st_q <= pulse_out_pkg::ST_IDLE;
					else
						cnt_q <= cnt_q - 1'b1;
				default:
					st_q <= pulse_out_pkg::ST_IDLE;
			endcase
		end
	end

	assign pulse = (st_q == pulse_out_pkg::ST_HIGH);
	assign busy  = (st_q != pulse_out_pkg::ST_IDLE);

endmodule // pulse_timer

// *** binary_outputs.sv ***
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Purpose: function selector for the binary and relay contact outputs
// Assumes: APB master on pclk; measurement inputs synchronous to pclk
// Notes:   relay contacts exist only when relay_fitted is high
module binary_outputs
#(
	parameter int unsigned TICK_CYCLES = pulse_out_pkg::TICK_CYCLES
)
(
	input  wire logic                                          pclk,
	input  wire logic                                          presetn,
	input  wire logic                                          psel,
	input  wire logic                                          penable,
	input  wire logic                                          pwrite,
	input  wire logic [11:0]                                   paddr,
	input  wire logic [31:0]                                   pwdata,
	output logic      [31:0]                                   prdata,
	output logic                                               pready,
	output logic                                               pslverr,
	input  wire logic                                          relay_fitted,
	input  wire logic                                          device_ok,
	input  wire logic                                          rotation_cw,
	input  wire logic [6:0]                                    limit_evt,
	input  wire pulse_out_pkg::energy_t [3:0]                  energy_ms,
	output logic      [pulse_out_pkg::NUM_OUT-1:0]             contact
);

	pulse_out_pkg::out_cfg_t                   cfg_q   [pulse_out_pkg::NUM_OUT];
	logic [pulse_out_pkg::ENERGY_W-1:0]        inc_q   [pulse_out_pkg::NUM_OUT];
	logic [pulse_out_pkg::NUM_OUT-1:0]         pulse_w;
	logic [pulse_out_pkg::NUM_OUT-1:0]         busy_w;
	logic [pulse_out_pkg::NUM_OUT-1:0]         contact_d;
	logic [pulse_out_pkg::NUM_OUT-1:0]         contact_q;
	logic [pulse_out_pkg::NUM_OUT-1:0]         evt_seen_q;
	logic [7:0]                                evt_all;
	logic [31:0]                               tick_cnt_q;
	logic                                      tick_q;
	logic                                      enable_q;
	logic                                      wr_en;
	logic                                      rd_en;
	logic                                      addr_ok;

	////////////////////////////////////////////////////////////////////////////

	// index of an output register, or NUM_OUT for anything unmapped
	function automatic int unsigned reg_index(input logic [11:0] addr, input logic [11:0] base);
		int unsigned idx;
		idx = pulse_out_pkg::NUM_OUT;
		if (addr >= base && addr < base + 12'(4 * pulse_out_pkg::NUM_OUT) && addr[1:0] == 2'b00)
			idx = int'(addr - base) >> 2;
		return idx;
	endfunction

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !pwrite;
	assign addr_ok = reg_index(paddr, pulse_out_pkg::OFS_CFG_BASE) < pulse_out_pkg::NUM_OUT
		|| reg_index(paddr, pulse_out_pkg::OFS_INC_BASE) < pulse_out_pkg::NUM_OUT
		|| paddr == pulse_out_pkg::OFS_STATUS || paddr == pulse_out_pkg::OFS_CTRL;
	assign pslverr = psel && penable && !addr_ok;
	// a group code past the last limit group reads as never signalling
	assign evt_all = {1'b0, limit_evt};

	////////////////////////////////////////////////////////////////////////////

	// millisecond timebase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q     <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable_q <= 1'b1;
		else if (wr_en && paddr == pulse_out_pkg::OFS_CTRL)
			enable_q <= pwdata[0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_en && !penable)
		begin
			prdata <= '0;
			if (reg_index(paddr, pulse_out_pkg::OFS_CFG_BASE) < pulse_out_pkg::NUM_OUT)
				prdata <= 32'(cfg_q[reg_index(paddr, pulse_out_pkg::OFS_CFG_BASE)]);
			else if (reg_index(paddr, pulse_out_pkg::OFS_INC_BASE) < pulse_out_pkg::NUM_OUT)
				prdata <= inc_q[reg_index(paddr, pulse_out_pkg::OFS_INC_BASE)];
			else if (paddr == pulse_out_pkg::OFS_STATUS)
				prdata <= {16'h0000, 3'h0, busy_w, 3'h0, contact_q};
			else if (paddr == pulse_out_pkg::OFS_CTRL)
				prdata <= {31'h0000_0000, enable_q};
		end
	end

	////////////////////////////////////////////////////////////////////////////

	genvar g;
	generate
		for (g = 0; g < pulse_out_pkg::NUM_OUT; g++)
		begin : g_out
			logic        fitted;
			logic        trig;
			logic [15:0] e_sel;

			// relay outputs stay open when the module is not fitted
			assign fitted = (g < pulse_out_pkg::NUM_BASE) || relay_fitted;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cfg_q[g] <= pulse_out_pkg::out_cfg_t'(pulse_out_pkg::CFG_RESET[pulse_out_pkg::CFG_W-1:0]);
					inc_q[g] <= pulse_out_pkg::INC_RESET;
				end
				else if (wr_en && reg_index(paddr, pulse_out_pkg::OFS_CFG_BASE) == g)
					cfg_q[g] <= pulse_out_pkg::out_cfg_t'(pwdata[pulse_out_pkg::CFG_W-1:0]);
				else if (wr_en && reg_index(paddr, pulse_out_pkg::OFS_INC_BASE) == g)
					inc_q[g] <= pwdata;
			end

			// group events arriving between ticks are held until the next tick
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					evt_seen_q[g] <= 1'b0;
				else if (evt_all[cfg_q[g].group])
					evt_seen_q[g] <= 1'b1;
				else if (tick_q)
					evt_seen_q[g] <= 1'b0;
			end

			assign trig  = (cfg_q[g].func == pulse_out_pkg::FN_LIMIT) && evt_seen_q[g];
			assign e_sel = cfg_q[g].supply ? energy_ms[cfg_q[g].source].supplied
				: energy_ms[cfg_q[g].source].consumed;

			pulse_timer u_timer
			(
				.pclk      (pclk),
				.presetn   (presetn),
				.tick      (tick_q),
				.cfg       (cfg_q[g]),
				.increment (inc_q[g]),
				.energy_in (tick_q ? e_sel : 16'h0000),
				.trigger   (trig),
				.busy      (busy_w[g]),
				.pulse     (pulse_w[g])
			);

			always_comb
			begin
				case (cfg_q[g].func)
					pulse_out_pkg::FN_OFF:    contact_d[g] = 1'b0;
					pulse_out_pkg::FN_ALIVE:  contact_d[g] = device_ok;
					pulse_out_pkg::FN_LIMIT:  contact_d[g] = pulse_w[g];
					pulse_out_pkg::FN_ENERGY: contact_d[g] = pulse_w[g];
					pulse_out_pkg::FN_ROTATE: contact_d[g] = rotation_cw;
					default:                  contact_d[g] = 1'b0;
				endcase
				if (!fitted || !enable_q)
					contact_d[g] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			contact_q <= '0;
		else
			contact_q <= contact_d;
	end

	assign contact = contact_q;

endmodule // binary_outputs

// *** binary_outputs_monitor.sv ***
// Purpose: checker on the contact outputs of the function selector
// Assumes: contact 0 carries only energy or limit pulses
// Notes:   output functions are snooped from apb writes
`timescale 1ns/1ns
module binary_outputs_monitor
#(
	parameter int unsigned TICK_CYCLES = 10
)
(
	input wire logic                                 pclk,
	input wire logic                                 presetn,
	input wire logic                                 psel,
	input wire logic                                 penable,
	input wire logic                                 pwrite,
	input wire logic [11:0]                          paddr,
	input wire logic [31:0]                          pwdata,
	input wire logic                                 relay_fitted,
	input wire logic                                 device_ok,
	input wire logic                                 rotation_cw,
	input wire logic [pulse_out_pkg::NUM_OUT-1:0]    contact
);
	localparam int T = TICK_CYCLES;
	logic [4:0][2:0] f_q;
	logic [4:0]      off, al, ro, ok;
	int              hi_q, lo_q, pr_q;
	logic            c_q;
	logic            en_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			f_q <= '0;
		else if (psel && penable && pwrite && paddr < 12'h014 && paddr[1:0] == 2'h0)
			f_q[paddr[4:2]] <= pwdata[2:0];
	// global enable snooped so that forced-open contacts are not flagged
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_q <= 1'b1;
		else if (psel && penable && pwrite && paddr == 12'h044)
			en_q <= pwdata[0];
	// low and period counts start at 1 << 20 and count up from there, so a first pulse is legal
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hi_q <= 0;
			lo_q <= 1 << 20;
			pr_q <= 1 << 20;
			c_q  <= 1'b0;
		end
		else
		begin
			c_q  <= contact[0];
			hi_q <= contact[0] ? hi_q + 1 : 0;
			lo_q <= contact[0] ? 0 : lo_q + 1;
			pr_q <= (contact[0] && !c_q) ? 1 : pr_q + 1;
		end
	always_comb
		for (int n = 0; n < 5; n++)
		begin
			off[n] = f_q[n] == 3'h0;
			al[n]  = f_q[n] == 3'h1;
			ro[n]  = f_q[n] == 3'h4;
		end
	assign ok = (relay_fitted ? 5'h1f : 5'h03) & {5{en_q}};
	////////////////////////////////////////////////
	property p_off;
		(contact & $past(off)) == 5'h0;
	endproperty
	a_off: assert property (p_off) else $error("unused output closed");
	property p_alive;
		$past(al) != 5'h0 |-> ((contact ^ {5{$past(device_ok)}}) & $past(al & ok)) == 5'h0;
	endproperty
	a_alive: assert property (p_alive) else $error("alive output wrong");
	property p_rot;
		$past(ro) != 5'h0 |-> ((contact ^ {5{$past(rotation_cw)}}) & $past(ro & ok)) == 5'h0;
	endproperty
	a_rot: assert property (p_rot) else $error("rotation output wrong");
	property p_relay;
		!$past(relay_fitted) |-> contact[4:2] == 3'h0;
	endproperty
	a_relay: assert property (p_relay) else $error("relay closed while absent");
	property p_low;
		$rose(contact[0]) |-> lo_q >= 50 * T - 1;
	endproperty
	a_low: assert property (p_low) else $error("low gap too short");
	property p_hlo;
		$fell(contact[0]) |-> hi_q >= 50 * T - 1;
	endproperty
	a_hlo: assert property (p_hlo) else $error("pulse too short");
	property p_hhi;
		$fell(contact[0]) |-> hi_q <= 500 * T + 1;
	endproperty
	a_hhi: assert property (p_hhi) else $error("pulse too long");
	property p_rate;
		$rose(contact[0]) |-> pr_q >= 100 * T - 1;
	endproperty
	a_rate: assert property (p_rate) else $error("pulse period too short");
endmodule // binary_outputs_monitor

// *** pulse_counter.sv ***
// Purpose: external pulse counter on one contact
// Assumes: clean contact, no bounce
// Notes:   a closure counts once it opens again, as a meter would
`timescale 1ns/1ns
module pulse_counter
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic line,
	output int        count
);
	logic prev_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prev_q <= 1'b0;
			count  <= 0;
		end
		else
		begin
			prev_q <= line;
			if (prev_q && !line)
				count <= count + 1;
		end
endmodule // pulse_counter

// *** tb_binary_outputs.sv ***
// Purpose: self-checking bench for the contact function selector
// Assumes: short millisecond tick, contact 0 used for pulses
// Notes:   reads are checked against a queue of expected words
`timescale 1ns/1ns
module tb_binary_outputs;
	localparam int T = 10;
	logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata;
	logic                         relay_fitted, device_ok, rotation_cw;
	logic [6:0]                   limit_evt;
	pulse_out_pkg::energy_t [3:0] energy_ms;
	logic [4:0]                   contact;
	int                           count, err_count, checks_done, cyc, v, n0;
	logic [32:0]                  exp_q[$];
	binary_outputs #(.TICK_CYCLES(T)) binary_outputs_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .relay_fitted, .device_ok,
		.rotation_cw, .limit_evt, .energy_ms, .contact);
	pulse_counter pulse_counter_inst (.pclk, .presetn, .line(contact[0]), .count);
	////////////////////////////////////////////////
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ms(input int k);
		repeat (k * T) @(posedge pclk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			chk({pslverr, prdata}, exp_q.pop_front());
	// the whole run needs about 40000 to 45000 cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_count++;
			end_of_test;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{relay_fitted, device_ok, rotation_cw, limit_evt} = '0;
		energy_ms = '0;
		v = $urandom(32'h48bc3c08);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			apb(0, 12'(4 * i), 0, 33'h0);
		apb(0, pulse_out_pkg::OFS_INC_BASE, 0, 33'h1);
		apb(1, 12'h048, 32'hffff_ffff, 0);
		apb(0, 12'h048, 0, 33'h1_0000_0000);
		$display("register test done");
		apb(1, 12'h004, 32'h1, 0);
		apb(1, 12'h008, 32'h4, 0);
		apb(1, 12'h00c, 32'h1, 0);
		apb(0, 12'h004, 0, 33'h1);
		for (int i = 0; i < 8; i++)
		begin
			{relay_fitted, device_ok, rotation_cw} <= 3'(i);
			repeat (3) @(posedge pclk);
			chk(33'(contact[4:1]), 33'({1'b0, i[2] & i[1], i[2] & i[0], i[1]}));
		end
		apb(0, pulse_out_pkg::OFS_STATUS, 0, 33'h0_0000_000e);
		apb(1, pulse_out_pkg::OFS_CTRL, 0, 0);
		apb(0, pulse_out_pkg::OFS_CTRL, 0, 33'h0);
		chk(33'(contact), 33'h0);
		apb(1, pulse_out_pkg::OFS_CTRL, 32'h1, 0);
		$display("static test done");
		v = $urandom_range(4, 1);
		// the unselected source and direction carry a large distractor
		energy_ms[0] <= {16'(v), 16'h00ff};
		energy_ms[1] <= {16'h00ff, 16'(v)};
		apb(1, pulse_out_pkg::OFS_INC_BASE, 32'd400, 0);
		for (int s = 0; s < 2; s++)
		begin
			apb(1, 12'h000, 32'h0b | (s << 7) | (s << 8), 0);
			n0 = count;
			ms(1200);
			chk(33'((count - n0) >= 3 * v - 2 && (count - n0) <= 3 * v + 1), 33'h1);
		end
		// steps above ten must clamp to the longest pulse
		apb(1, 12'h000, 32'h1db, 0);
		repeat (2) @(posedge pclk);
		while (contact[0])
			@(posedge pclk);
		while (!contact[0])
			@(posedge pclk);
		n0 = 0;
		while (contact[0])
		begin
			@(posedge pclk);
			n0++;
		end
		chk(33'(n0), 33'(pulse_out_pkg::STEP_MS * pulse_out_pkg::MAX_STEPS * T));
		$display("energy test done");
		energy_ms <= '0;
		apb(1, 12'h000, 32'h0c0a, 0);
		ms(700);
		for (int k = 0; k < 2; k++)
		begin
			n0 = count;
			limit_evt <= k ? 7'h08 : 7'h77;
			@(posedge pclk);
			limit_evt <= 7'h00;
			ms(200);
			chk(33'(count - n0), 33'(k));
		end
		$display("limit test done");
		end_of_test;
	end
endmodule // tb_binary_outputs
bind binary_outputs binary_outputs_monitor #(.TICK_CYCLES(TICK_CYCLES)) binary_outputs_monitor_inst
	(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .relay_fitted, .device_ok,
	.rotation_cw, .contact);
